//--- design/clfm_mapper.sv
// frame fifo and lane frame mapper for the converter's output link
`timescale 1ns/100ps

////////////////////////////////////////////////////////////////////////////////
// frame fifo, flip-flop storage, depth must be a power of two
module clfm_fifo
    import clfm_pkg::*;
#(
    parameter int WIDTH = FRAME_W,
    parameter int DEPTH = FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic s_valid,
    output logic s_ready,
    input wire logic [WIDTH-1:0] s_data,
    output logic m_valid,
    input wire logic m_ready,
    output logic [WIDTH-1:0] m_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];  // storage, no reset needed
    logic [AW-1:0] wr_q;              // write index
    logic [AW-1:0] rd_q;              // read index
    logic [AW:0] cnt_q;               // words held
    logic [AW:0] cnt_d;
    logic rdy_q;                      // registered not-full
    wire push = s_valid & rdy_q;
    wire pop = m_valid & m_ready;

    // ready is registered so the source sees a clean flop
    assign s_ready = rdy_q;
    assign m_valid = (cnt_q != '0);
    assign m_data = mem_q[rd_q];
    assign cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);

    // pointers and fill level
    always_ff @(posedge mclk) begin
        if (rst) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b0;
        end else begin
            if (push) begin
                wr_q <= AW'(wr_q + 1'b1);  // wraps, depth is a power of two
            end
            if (pop) begin
                rd_q <= AW'(rd_q + 1'b1);
            end
            cnt_q <= cnt_d;
            rdy_q <= (cnt_d != (AW+1)'(DEPTH));
        end
    end

    // storage write
    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wr_q] <= s_data;
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////////
// top: buffers frames and packs them into lane octets
module clfm_mapper
    import clfm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] link_mode_select,
    input wire clfm_part_t part_channels,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [FRAME_W-1:0] in_frame,
    output logic frame_valid,
    input wire logic frame_ready,
    output logic [LANE_W-1:0] lane0,
    output logic [LANE_W-1:0] lane1,
    output logic [LANE_W-1:0] lane2,
    output logic [LANE_W-1:0] lane3,
    output logic [LANE_W-1:0] lane4,
    output logic [LANE_W-1:0] lane5,
    output logic [LANE_W-1:0] lane6,
    output logic [LANE_W-1:0] lane7,
    output logic [7:0] lane_enable,
    output logic [2:0] octets_per_frame
);

    ////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // one sample slot of a frame word
    function automatic logic [SAMP_W-1:0] smp(input logic [FRAME_W-1:0] f, input int ch,
                                              input int n);
        return f[ch*CH_W + n*SAMP_W +: SAMP_W];
    endfunction

    // active lane count per mode and part
    function automatic logic [3:0] nlanes(input logic [3:0] m, input clfm_part_t p);
        logic [1:0] k;
        k = (p == PART_QUAD) ? 2'd0 : (p == PART_DUAL) ? 2'd1 : 2'd2;
        case (m)
            MODE_12B_8B10B, MODE_12B_66B: return (k == 0) ? 4'd6 : (k == 1) ? 4'd3 : 4'd2;
            MODE_8B_8B10B, MODE_10B_8B10B, MODE_8B_66B, MODE_12B_PAIR:
                return (k == 0) ? 4'd4 : (k == 1) ? 4'd2 : 4'd1;
            MODE_12B_3LANE: return (k == 0) ? 4'd3 : (k == 1) ? 4'd2 : 4'd1;
            MODE_8B_2OCTET: return (k == 0) ? 4'd2 : 4'd1;
            MODE_8B_SPLIT: return (k == 0) ? 4'd8 : (k == 1) ? 4'd4 : 4'd2;
            default: return 4'd0;  // unsupported mode: every lane powered down
        endcase
    endfunction

    // octets per lane per frame
    function automatic logic [2:0] noct(input logic [3:0] m);
        case (m)
            MODE_12B_8B10B, MODE_12B_66B, MODE_12B_3LANE, MODE_8B_2OCTET: return 3'd2;
            MODE_8B_8B10B, MODE_8B_66B, MODE_8B_SPLIT: return 3'd1;
            MODE_10B_8B10B: return 3'd5;
            MODE_12B_PAIR: return 3'd3;
            default: return 3'd0;
        endcase
    endfunction

    // one lane's frame, left justified so octet 0 leaves first
    function automatic logic [LANE_W-1:0] map_lane(input logic [3:0] m, input clfm_part_t p,
                                                   input logic [FRAME_W-1:0] f, input int ln);
        logic [95:0] s12;   // a0 a1 b0 b1 c0 c1 d0 d1 chained
        logic [47:0] s4;    // a0 b0 c0 d0 chained
        logic [31:0] s8;    // 8-bit a0 b0 c0 d0 chained
        logic [15:0] w16;
        logic [SAMP_W-1:0] x0;
        logic [SAMP_W-1:0] x1;
        logic [SAMP_W-1:0] x2;
        logic [SAMP_W-1:0] x3;
        logic [SAMP_W-1:0] xs;  // mode 9 slot picked by lane number
        int ch;
        ch = ln & 3;
        x0 = smp(f, ch, 0);
        x1 = smp(f, ch, 1);
        x2 = smp(f, ch, 2);
        x3 = smp(f, ch, 3);
        xs = smp(f, ln >> 1, ln & 1);
        s12 = {smp(f, 0, 0), smp(f, 0, 1), smp(f, 1, 0), smp(f, 1, 1),
               smp(f, 2, 0), smp(f, 2, 1), smp(f, 3, 0), smp(f, 3, 1)};
        s4 = {smp(f, 0, 0), smp(f, 1, 0), smp(f, 2, 0), smp(f, 3, 0)};
        s8 = {s4[43:36], s4[31:24], s4[19:12], s4[7:0]};  // low octet of each sample 0
        w16 = 16'h0000;
        case (m)
            // 16 bits per lane cut from the 96-bit chain
            MODE_12B_8B10B, MODE_12B_66B: begin
                if (ln < 6) begin
                    w16 = s12[95 - 16*ln -: 16];
                end
                if (ln == 1 && p == PART_SINGLE) begin
                    w16[7:0] = 8'h00;
                end
                return {w16, 24'h00_0000};
            end
            // one octet, one channel per lane
            MODE_8B_8B10B, MODE_8B_66B: begin
                return {x0[7:0], 32'h0000_0000};
            end
            // four 10-bit samples fill five octets
            MODE_10B_8B10B: begin
                return {x0[9:0], x1[9:0], x2[9:0], x3[9:0]};
            end
            // two 12-bit samples fill three octets
            MODE_12B_PAIR: begin
                return {x0, x1, 16'h0000};
            end
            // sample 0 of each channel chained over three lanes
            MODE_12B_3LANE: begin
                if (ln < 3) begin
                    w16 = s4[47 - 16*ln -: 16];
                end
                if (ln == 0 && p == PART_SINGLE) begin
                    w16[3:0] = 4'h0;
                end
                if (ln == 1 && p == PART_DUAL) begin
                    w16[7:0] = 8'h00;
                end
                return {w16, 24'h00_0000};
            end
            // two 8-bit samples per lane
            MODE_8B_2OCTET: begin
                if (ln < 2) begin
                    w16 = s8[31 - 16*ln -: 16];
                end
                if (ln == 0 && p == PART_SINGLE) begin
                    w16[7:0] = 8'h00;
                end
                return {w16, 24'h00_0000};
            end
            // even sample on the even lane, odd sample on the next
            MODE_8B_SPLIT: begin
                return {xs[7:0], 32'h0000_0000};
            end
            default: return LANE_RST;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // buffering

    logic fifo_valid;               // a frame waits in the fifo
    logic [FRAME_W-1:0] fifo_data;  // oldest frame
    logic frame_valid_q;            // output frame held for the receiver
    // a stalled receiver stops the pop, so the fifo fills and drops in_ready
    wire take = fifo_valid & (~frame_valid_q | frame_ready);

    clfm_fifo #(
        .WIDTH(FRAME_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .s_valid(in_valid),
        .s_ready(in_ready),
        .s_data(in_frame),
        .m_valid(fifo_valid),
        .m_ready(take),
        .m_data(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // lane packing

    wire [3:0] lanes_used = nlanes(link_mode_select, part_channels);
    // lowest lanes only; the rest stay low and disabled
    wire [7:0] lane_mask = 8'((9'h001 << lanes_used) - 9'h001);
    wire [LANE_W-1:0] lane_d [NUM_LANES];
    logic [LANE_W-1:0] lane_q [NUM_LANES];
    logic [7:0] lane_enable_q;
    logic [2:0] octets_q;

    // one packer and one output register per lane
    for (genvar g = 0; g < NUM_LANES; g++) begin : g_lane
        assign lane_d[g] = lane_mask[g] ?
            map_lane(link_mode_select, part_channels, fifo_data, g) : LANE_RST;

        // load on every accepted frame, hold while the receiver stalls
        always_ff @(posedge mclk) begin
            if (rst) begin
                lane_q[g] <= LANE_RST;
            end else if (take) begin
                lane_q[g] <= lane_d[g];
            end
        end
    end

    // frame handshake and per-frame lane settings
    always_ff @(posedge mclk) begin
        if (rst) begin
            frame_valid_q <= 1'b0;
            lane_enable_q <= LANE_EN_RST;
            octets_q <= OCTETS_RST;
        end else begin
            if (take) begin
                frame_valid_q <= 1'b1;
                lane_enable_q <= lane_mask;
                octets_q <= noct(link_mode_select);
            end else if (frame_ready) begin
                frame_valid_q <= 1'b0;  // taken by the receiver, nothing new
            end
        end
    end

    assign frame_valid = frame_valid_q;
    assign lane_enable = lane_enable_q;
    assign octets_per_frame = octets_q;
    assign lane0 = lane_q[0];
    assign lane1 = lane_q[1];
    assign lane2 = lane_q[2];
    assign lane3 = lane_q[3];
    assign lane4 = lane_q[4];
    assign lane5 = lane_q[5];
    assign lane6 = lane_q[6];
    assign lane7 = lane_q[7];

endmodule

//--- design/clfm_pkg.sv
// shared constants and types for the converter lane frame mapper
package clfm_pkg;

    // frame geometry
    localparam int SAMP_W = 12;              // every sample slot is 12 bits wide
    localparam int SAMPS = 4;                // sample slots per channel per frame
    localparam int CHANS = 4;                // channels a..d
    localparam int CH_W = SAMP_W * SAMPS;    // 48 bits per channel
    localparam int FRAME_W = CH_W * CHANS;   // 192-bit input frame word
    localparam int NUM_LANES = 8;            // serial lanes lane0..lane7
    localparam int LANE_W = 40;              // five octets, octet 0 in the top byte
    localparam int FIFO_DEPTH = 4;           // frames buffered ahead of the mapper

    // link mode codes on link_mode_select
    localparam logic [3:0] MODE_12B_8B10B = 4'h1;
    localparam logic [3:0] MODE_8B_8B10B = 4'h2;
    localparam logic [3:0] MODE_10B_8B10B = 4'h3;
    localparam logic [3:0] MODE_12B_3LANE = 4'h4;
    localparam logic [3:0] MODE_8B_2OCTET = 4'h5;
    localparam logic [3:0] MODE_12B_66B = 4'h6;
    localparam logic [3:0] MODE_8B_66B = 4'h7;
    localparam logic [3:0] MODE_12B_PAIR = 4'h8;
    localparam logic [3:0] MODE_8B_SPLIT = 4'h9;

    // values after reset
    localparam logic [7:0] LANE_EN_RST = 8'h00;
    localparam logic [2:0] OCTETS_RST = 3'h0;
    localparam logic [LANE_W-1:0] LANE_RST = 40'h00_0000_0000;

    // channel count of the part
    typedef enum logic [1:0] {
        PART_QUAD,
        PART_DUAL,
        PART_SINGLE
    } clfm_part_t;

endpackage

//--- tb/clfm_mapper_sva.sv
// assertion checker for the lane frame mapper outputs
`timescale 1ns/100ps
module clfm_mapper_chk
    import clfm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic [3:0] link_mode_select,
    input wire clfm_part_t part_channels,
    input wire logic frame_valid,
    input wire logic frame_ready,
    input wire logic [LANE_W-1:0] lane0,
    input wire logic [LANE_W-1:0] lane1,
    input wire logic [LANE_W-1:0] lane4,
    input wire logic [LANE_W-1:0] lane7,
    input wire logic [7:0] lane_enable,
    input wire logic [2:0] octets_per_frame
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    // part decode; the bench holds mode and part steady while a frame is out
    wire logic is_quad = part_channels == PART_QUAD;
    wire logic is_dual = part_channels == PART_DUAL;
    wire logic is_single = part_channels == PART_SINGLE;
    wire logic fv_mode1 = frame_valid && link_mode_select == MODE_12B_8B10B;
    ////////////////////////////////////////////////////////////////////////////////
    property p_m1_lanes;
        fv_mode1 |-> lane_enable == (is_quad ? 8'h3F : is_dual ? 8'h07 : 8'h03);
    endproperty
    a_m1_lanes: assert property (p_m1_lanes) else $error("mode 1 lane count");
    property p_m1_fill;
        fv_mode1 && is_single |-> lane1[31:24] == 8'h00;
    endproperty
    a_m1_fill: assert property (p_m1_fill) else $error("mode 1 zero octet");
    property p_m3_shape;
        frame_valid && link_mode_select == MODE_10B_8B10B |-> octets_per_frame == 3'h5
            && lane_enable == (is_quad ? 8'h0F : is_dual ? 8'h03 : 8'h01);
    endproperty
    a_m3_shape: assert property (p_m3_shape) else $error("mode 3 shape");
    property p_m4_nibble;
        frame_valid && link_mode_select == MODE_12B_3LANE && is_single
            |-> lane0[27:24] == 4'h0 && lane_enable == 8'h01;
    endproperty
    a_m4_nibble: assert property (p_m4_nibble) else $error("mode 4 zero nibble");
    property p_m5_fill;
        frame_valid && link_mode_select == MODE_8B_2OCTET && is_single |-> lane0[31:24] == 8'h00;
    endproperty
    a_m5_fill: assert property (p_m5_fill) else $error("mode 5 zero octet");
    property p_m8_tail;
        frame_valid && link_mode_select == MODE_12B_PAIR
            |-> octets_per_frame == 3'h3 && lane0[15:0] == 16'h0000;
    endproperty
    a_m8_tail: assert property (p_m8_tail) else $error("mode 8 octets");
    property p_m9_quad;
        frame_valid && link_mode_select == MODE_8B_SPLIT && is_quad
            |-> lane_enable == 8'hFF && lane7[31:0] == 32'h0000_0000;
    endproperty
    a_m9_quad: assert property (p_m9_quad) else $error("mode 9 lanes");
    property p_low_lanes;
        frame_valid |-> ((lane_enable + 8'h01) & lane_enable) == 8'h00;
    endproperty
    a_low_lanes: assert property (p_low_lanes) else $error("lanes not lowest");
    property p_idle_zero;
        !lane_enable[4] |-> lane4 == '0;
    endproperty
    a_idle_zero: assert property (p_idle_zero) else $error("idle lane not zero");
    // a stalled frame must not move under the receiver
    property p_hold;
        frame_valid && !frame_ready |=> frame_valid && $stable(lane0) && $stable(lane_enable);
    endproperty
    a_hold: assert property (p_hold) else $error("frame moved while stalled");
    c_m9: cover property (frame_valid && link_mode_select == MODE_8B_SPLIT && is_quad);
    c_stall: cover property (frame_valid && !frame_ready);
    c_m1_single: cover property (fv_mode1 && is_single);
endmodule
bind clfm_mapper clfm_mapper_chk clfm_mapper_chk_i (.mclk(mclk), .rst(rst),
    .link_mode_select(link_mode_select), .part_channels(part_channels),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .lane0(lane0), .lane1(lane1),
    .lane4(lane4), .lane7(lane7), .lane_enable(lane_enable),
    .octets_per_frame(octets_per_frame));

//--- tb/clfm_rx_model.sv
// receiving side model: takes lane frames, stalls on request
`timescale 1ns/100ps
module clfm_rx_model
    import clfm_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic stall,
    input wire logic frame_valid,
    input wire logic [LANE_W-1:0] lane0,
    output logic frame_ready,
    output logic [7:0] n_taken,
    output logic [LANE_W-1:0] last_lane0
);
    // ready is a plain level, so a stall holds the frame for as long as needed
    assign frame_ready = !stall;
    // count and keep what was taken off the link
    always_ff @(posedge mclk) begin
        if (rst) begin
            n_taken <= 8'h00;
            last_lane0 <= '0;
        end else if (frame_valid && frame_ready) begin
            n_taken <= n_taken + 8'h01;
            last_lane0 <= lane0;
        end
    end
endmodule

//--- tb/tb_clfm_mapper.sv
// self-checking bench for the lane frame mapper
`timescale 1ns/100ps
module tb_clfm_mapper;
    import clfm_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] mode = 4'h0;
    clfm_part_t part = PART_QUAD;
    logic in_valid = 1'b0;
    logic [FRAME_W-1:0] in_frame = '0;
    logic stall = 1'b0;
    logic in_ready, frame_valid, frame_ready;
    logic [LANE_W-1:0] ln [NUM_LANES];
    logic [LANE_W-1:0] last_lane0;
    logic [7:0] lane_enable, n_taken;
    logic [2:0] octets;
    int n_fail = 0;
    int checks_done = 0;
    int acc, r, p, k, nl;
    // rows: mode, lanes quad/dual/single, octets per lane
    logic [19:0] rows [9] = '{20'h1_6322, 20'h2_4211, 20'h3_4215, 20'h4_3212, 20'h5_2112,
        20'h6_6322, 20'h7_4211, 20'h8_4213, 20'h9_8421};
    clfm_mapper clfm_mapper_i (.mclk(mclk), .rst(rst), .link_mode_select(mode),
        .part_channels(part), .in_valid(in_valid), .in_ready(in_ready), .in_frame(in_frame),
        .frame_valid(frame_valid), .frame_ready(frame_ready), .lane0(ln[0]), .lane1(ln[1]),
        .lane2(ln[2]), .lane3(ln[3]), .lane4(ln[4]), .lane5(ln[5]), .lane6(ln[6]),
        .lane7(ln[7]), .lane_enable(lane_enable), .octets_per_frame(octets));
    clfm_rx_model clfm_rx_model_i (.mclk(mclk), .rst(rst), .stall(stall),
        .frame_valid(frame_valid), .lane0(ln[0]), .frame_ready(frame_ready),
        .n_taken(n_taken), .last_lane0(last_lane0));
    initial begin
        forever #10 mclk = ~mclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // sample slot value, tagged so frames and slots tell apart
    function automatic logic [11:0] sv(input logic [3:0] t, input int c, input int n);
        return {t, 2'(c), 2'(n), 4'(c * 4 + n + 3)};
    endfunction
    function automatic logic [FRAME_W-1:0] mkf(input logic [3:0] t);
        logic [FRAME_W-1:0] f;
        for (int c = 0; c < 16; c++) f[c*12 +: 12] = sv(t, c / 4, c % 4);
        return f;
    endfunction
    // expected lane word, octet 0 on top
    function automatic logic [39:0] xl(input logic [3:0] m, input int p, input int k,
        input logic [3:0] t, input int nl);
        logic [95:0] c6;
        logic [47:0] c4;
        logic [11:0] s [4];
        logic [11:0] q0, q1;
        logic [39:0] x;
        if (k >= nl) return '0;
        c6 = {sv(t,0,0), sv(t,0,1), sv(t,1,0), sv(t,1,1), sv(t,2,0), sv(t,2,1), sv(t,3,0),
            sv(t,3,1)};
        c4 = {sv(t,0,0), sv(t,1,0), sv(t,2,0), sv(t,3,0)};
        for (int n = 0; n < 4; n++) s[n] = sv(t, k % 4, n);
        q0 = sv(t, (m == 4'h5) ? 2 * k : k / 2, (m == 4'h5) ? 0 : k % 2);
        q1 = sv(t, 2 * k + 1, 0);
        x = '0;
        case (m)
            4'h1, 4'h6: x = {c6[95-16*k -: 16], 24'h00_0000};
            4'h2, 4'h7: x = {s[0][7:0], 32'h0000_0000};
            4'h3: x = {s[0][9:0], s[1][9:0], s[2][9:0], s[3][9:0]};
            4'h4: x = {c4[47-16*k -: 16], 24'h00_0000};
            4'h5: x = {q0[7:0], q1[7:0], 24'h00_0000};
            4'h8: x = {s[0], s[1], 16'h0000};
            default: x = {q0[7:0], 32'h0000_0000};
        endcase
        if ((m == 4'h1 || m == 4'h6) && p == 2 && k == 1) x[31:24] = 8'h00;
        if (m == 4'h4 && p == 2) x[27:24] = 4'h0;
        if (m == 4'h4 && p == 1 && k == 1) x[31:24] = 8'h00;
        if (m == 4'h5 && p == 2) x[31:24] = 8'h00;
        return x;
    endfunction
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks_done++;
        if (got !== exp) begin
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask
    // offer one frame at a falling edge, hold it until ready was seen
    task automatic send(input logic [3:0] t);
        int i;
        in_frame = mkf(t);
        in_valid = 1'b1;
        for (i = 0; i < 20 && in_ready !== 1'b1; i++) @(negedge mclk);
        if (i == 20) begin
            n_fail++;
            wrap_up();
        end
        @(negedge mclk);
        in_valid = 1'b0;
    endtask
    // advance to the next falling edge that shows a frame
    task automatic wv;
        int i;
        for (i = 0; i < 20; i++) begin
            @(negedge mclk);
            if (frame_valid === 1'b1) break;
        end
        if (i == 20) begin
            n_fail++;
            wrap_up();
        end
    endtask
    task automatic chk_idle;
        chk(in_ready, 0);
        chk(frame_valid, 0);
        chk(lane_enable, 0);
        chk(octets, 0);
        chk(ln[0], 0);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(negedge mclk);
        chk_idle();
        rst = 1'b0;
        @(negedge mclk);
        // every mode on every part
        for (r = 0; r < 9; r++) begin
            for (p = 0; p < 3; p++) begin
                mode = rows[r][19:16];
                part = clfm_part_t'(p);
                nl = rows[r][15-4*p -: 4];
                send(4'(r));
                wv();
                chk(lane_enable, 8'((16'h0001 << nl) - 1));
                chk(octets, rows[r][2:0]);
                for (k = 0; k < 8; k++) chk(ln[k], xl(mode, p, k, 4'(r), nl));
                @(negedge mclk);
            end
        end
        // fill while stalled, then drain in order
        mode = MODE_8B_8B10B;
        part = PART_QUAD;
        stall = 1'b1;
        acc = 0;
        for (k = 0; k < 8; k++) begin
            in_frame = mkf(4'(acc));
            in_valid = 1'b1;
            if (in_ready === 1'b1) acc++;
            @(negedge mclk);
        end
        in_valid = 1'b0;
        chk(acc, 5);
        chk(ln[0], xl(mode, 0, 0, 4'h0, 4));
        stall = 1'b0;
        for (k = 1; k < 5; k++) begin
            wv();
            chk(ln[0], xl(mode, 0, 0, 4'(k), 4));
        end
        @(negedge mclk);
        chk(n_taken, 32);
        chk(last_lane0, xl(mode, 0, 0, 4'h4, 4));
        // codes outside 1..9 enable nothing
        for (k = 0; k < 2; k++) begin
            mode = k ? 4'hA : 4'h0;
            send(4'h7);
            repeat (3) @(negedge mclk);
            chk(lane_enable, 0);
            chk(octets, 0);
            chk(in_ready, 1);
        end
        // reset in mid-run with a frame held
        stall = 1'b1;
        mode = MODE_12B_PAIR;
        send(4'h3);
        wv();
        rst = 1'b1;
        @(negedge mclk);
        chk_idle();
        rst = 1'b0;
        stall = 1'b0;
        @(negedge mclk);
        chk(in_ready, 1);
        wrap_up();
    end
endmodule
